/* File: rtl/cmt_regs.svh */
`ifndef CMT_TIMER_REGS_SVH
`define CMT_TIMER_REGS_SVH

// Counter and prescaler width
`define CMT_CNT_W 32
// Number of match registers
`define CMT_NMATCH 4
// Most capture channels a pin-connected timer offers
`define CMT_MAX_CAP 4
// Most match outputs usable as single-edge PWM
`define CMT_MAX_PWM 3
// Reset value of counter, prescaler and captures
`define CMT_CNT_RST 32'h0000_0000
// Pin action codes on match
`define CMT_ACT_NONE 2'h0
`define CMT_ACT_LOW 2'h1
`define CMT_ACT_HIGH 2'h2
`define CMT_ACT_TOG 2'h3
// Edge select bits: bit 0 rising, bit 1 falling
`define CMT_EDGE_RISE_BIT 0
`define CMT_EDGE_FALL_BIT 1
// Count step and prescale increment
`define CMT_ONE 32'h0000_0001

`endif

/* File: rtl/cmt_pkg.sv */
package cmt_pkg;

  // Source of count steps
  typedef enum logic {
    CMT_MODE_TIMER = 1'b0,
    CMT_MODE_COUNT = 1'b1
  } cmt_mode_t;

  // Per match register configuration
  typedef struct packed {
    logic [31:0] value;   // Compare value
    logic int_en;         // Pulse interrupt on match
    logic dma_en;         // Pulse DMA request on match
    logic rst_en;         // Return counter to zero on match
    logic stop_en;        // Halt counter on match
    logic [1:0] act;      // Pin action on match
    logic pwm_en;         // Use pin as single-edge PWM
  } cmt_match_cfg_t;

  // Per capture channel configuration
  typedef struct packed {
    logic [1:0] edge_sel; // Rising / falling capture edges
    logic int_en;         // Pulse interrupt on capture
  } cmt_cap_cfg_t;

  // Global configuration
  typedef struct packed {
    logic enable;         // Counter runs
    cmt_mode_t mode;      // Timer or counter mode
    logic [1:0] cnt_edge; // Edges of external clock that count
    logic [31:0] presc;   // Prescaler terminal value
    logic clr_en;         // Clear on designated capture event
    logic [1:0] clr_sel;  // Capture channel that clears
    logic [1:0] clr_edge; // Edges of that channel that clear
  } cmt_cfg_t;

  // Whole state of the timer core
  typedef struct packed {
    logic [31:0] tc;
    logic [31:0] pc;
    logic halted;
    logic [3:0] pin;
    logic [3:0] match_irq;
    logic [3:0] dma_req;
    logic [3:0] cap_irq;
    logic [3:0][31:0] cap;
  } cmt_state_t;

endpackage : cmt_pkg

/* File: rtl/cmt_edge.sv */
`timescale 1ns/1ps
// Edge detector for synchronous inputs, one flop per bit
module cmt_edge #(
  parameter int W = 5
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] sig,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // Previous sample of each input
  typedef struct packed {
    logic [W-1:0] prev;
  } cmt_edge_st_t;

  cmt_edge_st_t st_q; // Registered state
  cmt_edge_st_t st_d; // Next state

  // Sample every input each cycle
  always_comb begin
    st_d = st_q;
    st_d.prev = sig;
  end

  // Inputs idle low out of reset, so a high input gives one rise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Per bit edge decode
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      assign rise[b] = sig[b] & ~st_q.prev[b];
      assign fall[b] = ~sig[b] & st_q.prev[b];
    end
  endgenerate

endmodule : cmt_edge

/* File: rtl/cmt_timer.sv */
`timescale 1ns/1ps
`include "cmt_regs.svh"

// Operation
// RL1: Counter advances once per prescaler wrap
// RL2: Count system clock or external clock edges
// RL3: Four matches raise interrupt, DMA, actions
// RL4: Match may let counting simply continue
// RL5: Match may halt the counter
// RL6: Match may return counter to zero
// RL7: Match pins go low, high, toggle, hold
// RL8: Capture channels latch count on edges
// RL9: Designated capture clears counter and prescaler
// RL10: Three match pins serve as PWM
// RL11: Pinless instances keep only internal functions; pinless builds here still count external clock edges in counter mode
// RL12: Match when count equals value per step
module cmt_timer #(
  parameter bit HAS_PINS = 1'b1,
  parameter int NUM_CAP = `CMT_MAX_CAP,
  parameter int NUM_PWM = `CMT_MAX_PWM
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input cmt_pkg::cmt_cfg_t cfg,
  input cmt_pkg::cmt_match_cfg_t [3:0] mcfg,
  input cmt_pkg::cmt_cap_cfg_t [3:0] ccfg,
  input wire logic sw_clear,
  input wire logic ext_clk,
  input wire logic [3:0] cap_in,
  output logic [31:0] count,
  output logic [31:0] prescale,
  output logic halted,
  output logic [3:0][31:0] cap_val,
  output logic [3:0] match_pin,
  output logic [3:0] match_irq,
  output logic [3:0] dma_req,
  output logic [3:0] cap_irq
);

  // Refuse channel counts the datapath cannot hold
  generate
    if (NUM_CAP < 0 || NUM_CAP > `CMT_MAX_CAP || NUM_PWM < 0 || NUM_PWM > `CMT_MAX_PWM) begin : g_chk
      $error("cmt_timer: NUM_CAP or NUM_PWM out of range");
    end
  endgenerate

  cmt_pkg::cmt_state_t st_q; // Registered state
  cmt_pkg::cmt_state_t st_d; // Next state
  logic [4:0] rise; // Rising edges, bit 4 is the external clock
  logic [4:0] fall; // Falling edges
  logic [3:0] cap_ev; // Capture event per channel
  logic [3:0] mhit; // Match hit per register
  logic [3:0] pwm_on; // Channel acts as PWM
  logic ext_step; // Selected external clock edge
  logic step; // Prescaler advances this cycle
  logic wrap; // Prescaler wraps, counter moves
  logic cap_clr; // Designated capture clear
  logic clr_any; // Clear counter and prescaler
  logic any_rst; // Some hit resets the counter
  logic any_stop; // Some hit halts the counter

  // One shared detector for capture pins and the external clock
  cmt_edge #(
    .W(5)
  ) u_edge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sig({ext_clk, cap_in}),
    .rise(rise),
    .fall(fall)
  );

  // RL2: external edge choice
  assign ext_step = (rise[4] & cfg.cnt_edge[`CMT_EDGE_RISE_BIT]) |
                    (fall[4] & cfg.cnt_edge[`CMT_EDGE_FALL_BIT]);

  // RL2: step source
  assign step = cfg.enable & ~st_q.halted &
                ((cfg.mode == cmt_pkg::CMT_MODE_TIMER) | ext_step);

  // RL1: prescaler terminal
  assign wrap = step & (st_q.pc == cfg.presc);

  // RL9: designated capture event, only where pins exist
  assign cap_clr = HAS_PINS & cfg.clr_en & (int'(cfg.clr_sel) < NUM_CAP) &
                   ((rise[cfg.clr_sel] & cfg.clr_edge[`CMT_EDGE_RISE_BIT]) |
                    (fall[cfg.clr_sel] & cfg.clr_edge[`CMT_EDGE_FALL_BIT]));
  assign clr_any = sw_clear | cap_clr;

  // Per channel compare and capture decode
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      // RL12: compare once per count step
      assign mhit[g] = wrap & (st_q.tc == mcfg[g].value);
      // RL10: only the low channels may be PWM
      assign pwm_on[g] = HAS_PINS & (g < NUM_PWM) & mcfg[g].pwm_en;
      // RL11: capture exists only with pins
      assign cap_ev[g] = HAS_PINS & (g < NUM_CAP) &
                         ((rise[g] & ccfg[g].edge_sel[`CMT_EDGE_RISE_BIT]) |
                          (fall[g] & ccfg[g].edge_sel[`CMT_EDGE_FALL_BIT]));
    end
  endgenerate

  // Reset and stop requests of all simultaneous hits act together
  always_comb begin
    any_rst = 1'b0;
    any_stop = 1'b0;
    for (int i = 0; i < 4; i++) begin
      any_rst = any_rst | (mhit[i] & mcfg[i].rst_en);
      any_stop = any_stop | (mhit[i] & mcfg[i].stop_en);
    end
  end

  // Next state of the whole timer
  always_comb begin
    st_d = st_q;
    st_d.match_irq = '0;
    st_d.dma_req = '0;
    st_d.cap_irq = '0;
    // Dropping enable is the way to release a halt
    if (!cfg.enable) begin
      st_d.halted = 1'b0;
    end
    // RL8: snapshot count before it moves
    for (int i = 0; i < 4; i++) begin
      if (cap_ev[i]) begin
        st_d.cap[i] = st_q.tc;
        st_d.cap_irq[i] = ccfg[i].int_en;
      end
    end
    if (clr_any) begin
      // RL9: clear beats counting, match halt and match reset; match pulses and non-PWM pin actions still happen
      st_d.tc = `CMT_CNT_RST;
      st_d.pc = `CMT_CNT_RST;
    end else if (wrap) begin
      st_d.pc = `CMT_CNT_RST;
      if (any_stop) begin
        // RL5: halt holds the matched value, or zero when a reset hit comes with it
        st_d.halted = 1'b1;
      end
      if (any_rst) begin
        // RL6: return to zero
        st_d.tc = `CMT_CNT_RST;
      end else if (!any_stop) begin
        // RL4: keep counting through the match
        st_d.tc = st_q.tc + `CMT_ONE;
      end
    end else if (step) begin
      // RL1: prescaler runs between counter steps
      st_d.pc = st_q.pc + `CMT_ONE;
    end
    // RL3: match reporting
    st_d.match_irq = mhit & {mcfg[3].int_en, mcfg[2].int_en, mcfg[1].int_en, mcfg[0].int_en};
    st_d.dma_req = mhit & {mcfg[3].dma_en, mcfg[2].dma_en, mcfg[1].dma_en, mcfg[0].dma_en};
    for (int i = 0; i < 4; i++) begin
      if (pwm_on[i]) begin
        // RL10: low at period start, high from its match
        if (clr_any || (wrap && any_rst)) begin
          st_d.pin[i] = 1'b0;
        end
        if (mhit[i] && !clr_any) begin
          st_d.pin[i] = 1'b1;
        end
      end else if (mhit[i]) begin
        // RL7: pin action on match
        unique case (mcfg[i].act)
          `CMT_ACT_NONE: st_d.pin[i] = st_q.pin[i];
          `CMT_ACT_LOW: st_d.pin[i] = 1'b0;
          `CMT_ACT_HIGH: st_d.pin[i] = 1'b1;
          `CMT_ACT_TOG: st_d.pin[i] = ~st_q.pin[i];
        endcase
      end
    end
    // RL11: pinless build never drives the pins
    if (!HAS_PINS) begin
      st_d.pin = '0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Everything visible comes straight from flops
  assign count = st_q.tc;
  assign prescale = st_q.pc;
  assign halted = st_q.halted;
  assign cap_val = st_q.cap;
  assign match_pin = st_q.pin;
  assign match_irq = st_q.match_irq;
  assign dma_req = st_q.dma_req;
  assign cap_irq = st_q.cap_irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_presc_only: assert property ( // RL1
    step && !wrap && !clr_any |=> prescale == $past(prescale) + `CMT_ONE && $stable(count))
    else $error("prescaler step moved counter or missed");
  a_timer_steps: assert property ( // RL2
    cfg.enable && !halted && cfg.mode == cmt_pkg::CMT_MODE_TIMER && !clr_any && !any_rst &&
    !any_stop |=> count != $past(count) || prescale != $past(prescale))
    else $error("timer mode did not step");
  a_count_gate: assert property ( // RL2
    cfg.mode == cmt_pkg::CMT_MODE_COUNT && !ext_step && !clr_any
    |=> $stable(count) && $stable(prescale))
    else $error("counter mode stepped without edge");
  a_match_irq: assert property ( // RL3
    mhit[2] && mcfg[2].int_en
    |=> match_irq[2] ##1 (!match_irq[2] || $past(mhit[2] && mcfg[2].int_en)))
    else $error("match interrupt not a pulse");
  a_match_cont: assert property ( // RL4
    wrap && !any_rst && !any_stop && !clr_any |=> count == $past(count) + `CMT_ONE)
    else $error("counter did not continue");
  a_match_stop: assert property ( // RL5
    wrap && any_stop && !any_rst && !clr_any && cfg.enable
    |=> halted && $stable(count) ##1 (!cfg.enable || $stable(count) || clr_any))
    else $error("stop on match failed");
  a_match_reset: assert property ( // RL6
    wrap && any_rst && !clr_any |=> count == `CMT_CNT_RST)
    else $error("reset on match failed");
  a_pin_toggle: assert property ( // RL7
    HAS_PINS && mhit[2] && !pwm_on[2] && mcfg[2].act == `CMT_ACT_TOG
    |=> match_pin[2] != $past(match_pin[2]))
    else $error("toggle on match failed");
  a_cap_latch: assert property ( // RL8
    cap_ev[0] |=> cap_val[0] == $past(count))
    else $error("capture did not latch count");
  a_cap_clear: assert property ( // RL9
    cap_clr |=> count == `CMT_CNT_RST && prescale == `CMT_CNT_RST)
    else $error("capture clear failed");
  a_pwm_high: assert property ( // RL10
    pwm_on[0] && mhit[0] && !clr_any |=> match_pin[0])
    else $error("pwm output not high after match");
  a_no_pins: assert property ( // RL11
    !HAS_PINS |-> match_pin == '0 && cap_ev == '0)
    else $error("pinless instance drove pins");
  a_match_eq: assert property ( // RL12
    wrap && count == mcfg[2].value && mcfg[2].dma_en |=> dma_req[2])
    else $error("equal compare missed");

endmodule : cmt_timer

/* File: testbench/cmt_pin_model.sv */
`timescale 1ns/1ps
// Far side of the timer: capture sources, external clock and match pin load
module cmt_pin_model (
  input wire logic sys_clk,
  input wire logic [3:0] match_pin,
  output logic ext_clk,
  output logic [3:0] cap_in
);
  // Rising edges seen on match output 0, as a load counts PWM periods
  int pin0_rises = 0;
  logic pin0_q = 1'b0; // Previous level of match output 0

  // Sources idle low; the external clock stands still between bursts
  initial begin
    ext_clk = 1'b0;
    cap_in = 4'h0;
  end

  // Sample output 0 like a flop and count its rising edges
  always @(posedge sys_clk) begin
    pin0_q <= match_pin[0];
    if (match_pin[0] && !pin0_q) begin
      pin0_rises <= pin0_rises + 1;
    end
  end

  // Burst of external clock pulses, each level held one full cycle so no edge is lost
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      ext_clk = 1'b1;
      @(negedge sys_clk);
      ext_clk = 1'b0;
    end
  endtask : ext_pulses

  // Level change on one capture input, called just after a falling edge
  task automatic set_cap(input int i, input logic v);
    cap_in[i] = v;
  endtask : set_cap
endmodule : cmt_pin_model

/* File: testbench/test_cmt_timer.sv */
`timescale 1ns/1ps
// Compare a seen value with an expected one and count both outcomes
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module test_cmt_timer;
  logic sys_clk, rst_n, sw_clear, ext_clk;
  logic [3:0] cap_in, match_pin, match_irq, dma_req, cap_irq;
  logic [31:0] count, prescale;
  logic halted;
  logic [3:0][31:0] cap_val;
  cmt_pkg::cmt_cfg_t cfg;
  cmt_pkg::cmt_match_cfg_t [3:0] mcfg;
  cmt_pkg::cmt_cap_cfg_t [3:0] ccfg;
  int err_count = 0;
  int cmp_count = 0;
  logic [31:0] np_count; // Count of the pinless build
  logic [3:0] np_pin; // Match outputs of the pinless build
  logic [3:0] np_cap_irq; // Capture pulses of the pinless build

  cmt_timer cmt_timer_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg), .mcfg(mcfg),
    .ccfg(ccfg), .sw_clear(sw_clear), .ext_clk(ext_clk), .cap_in(cap_in), .count(count),
    .prescale(prescale), .halted(halted), .cap_val(cap_val), .match_pin(match_pin),
    .match_irq(match_irq), .dma_req(dma_req), .cap_irq(cap_irq));
  cmt_pin_model cmt_pin_model_inst (.sys_clk(sys_clk), .match_pin(match_pin),
    .ext_clk(ext_clk), .cap_in(cap_in));

  // Pinless build on the same inputs: counting and match pulses, external clock edges included, no pins or captures
  if (1'b1) begin : g_pinless
    cmt_timer #(.HAS_PINS(1'b0)) cmt_timer_inst (.sys_clk(sys_clk), .rst_n(rst_n), .cfg(cfg),
      .mcfg(mcfg), .ccfg(ccfg), .sw_clear(sw_clear), .ext_clk(ext_clk), .cap_in(cap_in),
      .count(np_count), .prescale(), .halted(), .cap_val(), .match_pin(np_pin), .match_irq(),
      .dma_req(), .cap_irq(np_cap_irq));
  end

  // 25 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Let n rising edges pass, then stop on a falling edge where outputs are settled
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : step

  // Park all configuration and zero counter and prescaler through the clear input
  task automatic park();
    cfg = '0;
    mcfg = '0;
    ccfg = '0;
    sw_clear = 1'b1;
    step(1);
    sw_clear = 1'b0;
  endtask : park

  task automatic t_prescale();
    park();
    cfg.presc = 32'h0000_0001;
    cfg.enable = 1'b1;
    step(9);
    `CHK("count", 32'h0000_0004, count)
    `CHK("prescale", 32'h0000_0001, prescale)
  endtask : t_prescale

  task automatic t_match_reset();
    int irq;
    int dma;
    logic [31:0] mx;
    irq = 0;
    dma = 0;
    mx = '0;
    park();
    mcfg[2].value = 32'h0000_0002;
    mcfg[2].rst_en = 1'b1;
    mcfg[2].int_en = 1'b1;
    mcfg[2].dma_en = 1'b1;
    cfg.enable = 1'b1;
    repeat (31) begin
      step(1);
      irq += int'(match_irq[2] === 1'b1);
      dma += int'(dma_req[2] === 1'b1);
      if (count > mx) mx = count;
    end
    `CHK("max count", 32'h0000_0002, mx)
    `CHK("irq pulses", 10, irq)
    `CHK("dma pulses", 10, dma)
  endtask : t_match_reset

  task automatic t_stop();
    park();
    mcfg[1].value = 32'h0000_0005;
    mcfg[1].stop_en = 1'b1;
    cfg.enable = 1'b1;
    step(10);
    `CHK("halted", 1'b1, halted)
    `CHK("held count", 32'h0000_0005, count)
    cfg.enable = 1'b0;
    step(1);
    `CHK("released", 1'b0, halted)
  endtask : t_stop

  task automatic t_ext_count();
    park();
    cfg.mode = cmt_pkg::CMT_MODE_COUNT;
    cfg.cnt_edge = 2'h1;
    cfg.enable = 1'b1;
    cmt_pin_model_inst.ext_pulses(5);
    step(2);
    `CHK("ext count", 32'h0000_0005, count)
    cfg.cnt_edge = 2'h2;
    cmt_pin_model_inst.ext_pulses(3);
    step(2);
    `CHK("ext fall count", 32'h0000_0008, count)
  endtask : t_ext_count

  task automatic t_capture();
    logic [31:0] c;
    park();
    ccfg[0].edge_sel = 2'h1;
    ccfg[0].int_en = 1'b1;
    cfg.clr_en = 1'b1;
    cfg.clr_sel = 2'h1;
    cfg.clr_edge = 2'h1;
    cfg.enable = 1'b1;
    step(7);
    c = count;
    cmt_pin_model_inst.set_cap(0, 1'b1);
    step(1);
    `CHK("cap value", c, cap_val[0])
    `CHK("cap irq", 1'b1, cap_irq[0])
    `CHK("pinless cap irq", 4'h0, np_cap_irq)
    step(3);
    cmt_pin_model_inst.set_cap(1, 1'b1);
    step(1);
    `CHK("cleared count", 32'h0000_0000, count)
    `CHK("cleared prescale", 32'h0000_0000, prescale)
    `CHK("pinless uncleared", 32'h0000_000c, np_count)
    cmt_pin_model_inst.set_cap(0, 1'b0);
    cmt_pin_model_inst.set_cap(1, 1'b0);
  endtask : t_capture

  // pin actions on match, run twice so each of low, high and toggle changes a pin
  task automatic t_pins(input logic [7:0] acts, input logic [3:0] exp);
    park();
    for (int i = 0; i < 4; i++) begin
      mcfg[i].value = 32'h0000_0003;
      mcfg[i].act = acts[2*i+:2];
    end
    cfg.enable = 1'b1;
    step(6);
    `CHK("pins", exp, match_pin)
    `CHK("pinless pins", 4'h0, np_pin)
  endtask : t_pins

  // PWM on channel 0, period from a reset match on channel 3
  task automatic t_pwm();
    int r;
    park();
    r = cmt_pin_model_inst.pin0_rises;
    mcfg[0].value = 32'h0000_0002;
    mcfg[0].pwm_en = 1'b1;
    mcfg[3].value = 32'h0000_0005;
    mcfg[3].rst_en = 1'b1;
    // Channel 3 is beyond the PWM channels, so its enable must do nothing
    mcfg[3].pwm_en = 1'b1;
    cfg.enable = 1'b1;
    step(4);
    `CHK("pwm high", 1'b1, match_pin[0])
    step(3);
    `CHK("pwm low", 1'b0, match_pin[0])
    `CHK("pwm ch3 held", 1'b0, match_pin[3])
    `CHK("period restart", 32'h0000_0001, count)
    step(3);
    `CHK("pwm rises", 1, cmt_pin_model_inst.pin0_rises - r)
  endtask : t_pwm

  // Verdict and end of run
  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // Watchdog well beyond the roughly 120 cycles the scenarios need
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    final_report();
  end

  // Main sequence: reset for five cycles, then the scenarios
  initial begin
    rst_n = 1'b0;
    sw_clear = 1'b0;
    cfg = '0;
    mcfg = '0;
    ccfg = '0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    t_prescale();
    t_match_reset();
    t_stop();
    t_ext_count();
    t_capture();
    t_pins(8'b00_11_10_01, 4'b0110);
    t_pins(8'b00_11_01_10, 4'b0001);
    t_pwm();
    final_report();
  end
endmodule : test_cmt_timer
